// ==== rtl/sfcf_defs.svh ====
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH
// ==========================================
// Opcodes
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FAST 8'h0B
`define SFCF_OP_DOR 8'h3B
`define SFCF_OP_DIOR 8'hBB
`define SFCF_OP_QOR 8'h6B
`define SFCF_OP_QIOR 8'hEB
`define SFCF_OP_PGE 8'h81
`define SFCF_OP_SECE 8'h20
`define SFCF_OP_HBE 8'h52
`define SFCF_OP_FBE 8'hD8
`define SFCF_OP_CE1 8'h60
`define SFCF_OP_CE2 8'hC7
`define SFCF_OP_PP 8'h02
`define SFCF_OP_DPP 8'hA2
`define SFCF_OP_QPP 8'h32
`define SFCF_OP_SUS1 8'h75
`define SFCF_OP_SUS2 8'hB0
`define SFCF_OP_RES1 8'h7A
`define SFCF_OP_RES2 8'h30
`define SFCF_OP_WEN 8'h06
`define SFCF_OP_WDI 8'h04
`define SFCF_OP_VWEN 8'h50
`define SFCF_OP_SAE 8'h44
`define SFCF_OP_SAP 8'h42
`define SFCF_OP_SAR 8'h48
`define SFCF_OP_RSL 8'h05
`define SFCF_OP_RSH 8'h35
`define SFCF_OP_RCF 8'h15
`define SFCF_OP_INTE 8'h25
`define SFCF_OP_WSR 8'h01
`define SFCF_OP_WCR 8'h31
// ==========================================
// Region masks and register layout
`define SFCF_PAGE_MASK 24'h0000FF
`define SFCF_SECT_MASK 24'h000FFF
`define SFCF_HBLK_MASK 24'h007FFF
`define SFCF_FBLK_MASK 24'h00FFFF
`define SFCF_CHIP_MASK 24'h1FFFFF
`define SFCF_SR_QE 9
`define SFCF_SR_RST 14'h0000
`define SFCF_CR_RST 8'h00
`endif

// ==== rtl/sfcf_pkg.sv ====
package sfcf_pkg;
	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_DATA = 3'b011,
		ST_STANDBY = 3'b100
	} sfcf_state_t;

	typedef enum logic [4:0] {
		K_NONE = 5'b00000,
		K_READ = 5'b00001,
		K_SECREAD = 5'b00010,
		K_STLO = 5'b00011,
		K_STHI = 5'b00100,
		K_CFGRD = 5'b00101,
		K_PROG = 5'b00110,
		K_SECPROG = 5'b00111,
		K_ERASE = 5'b01000,
		K_SECERASE = 5'b01001,
		K_CHIPERASE = 5'b01010,
		K_SET_WRITE_LATCH_CMD = 5'b01011,
		K_CLEAR_WRITE_LATCH_CMD = 5'b01100,
		K_VOLATILE_STATUS_WRITE_ENABLE_CMD = 5'b01101,
		K_STATUS_WRITE_CMD = 5'b01110,
		K_CONFIG_WRITE_CMD = 5'b01111,
		K_INTE = 5'b10000,
		K_SUSRES = 5'b10001
	} sfcf_kind_t;

	// Flags: addr, dummy, din, dout, arr, prot, quad
	typedef struct packed {
		logic ok;
		sfcf_kind_t kind;
		logic [6:0] fl;
		logic [2:0] alw;
		logic [2:0] dlw;
		logic [23:0] rmask;
	} sfcf_cmd_t;
endpackage

// ==== rtl/sfcf_top.sv ====
`timescale 1ns/10ps
`include "sfcf_defs.svh"
// Behaviour
// - Skip program/erase touching protected area
// - 4K sectors 0-511, block and chip erase
// - Unknown opcode: standby, output off till CS
// - Valid opcode stays active until CS rises
// - Sample on clock rise, launch on fall
// - Reads end at once when CS rises
// - Write-type commands need byte-aligned CS rise
// - Ignore array commands while busy
// - Dual reads use two data lines
// - Quad reads use four lines, need quad bit
// - Hold pauses link only, not operations
// - Hold edges take effect with clock low
// - Hold: output off, input ignored
// - CS rise during hold resets interface
// - No hold in quad mode
// - 03h read, 0Bh fast read with dummy
// - 3Bh BBh 6Bh EBh multi-line reads
// - Page, sector, block and chip erase opcodes
// - 02h A2h 32h page program opcodes
// - 06h/04h latch control, 50h volatile status
// - Secure area erase, program and read
// - Status/config reads and writes, 25h
// - Modifying commands need write latch set; 01h after 50h runs without it
// - Latch cleared by listed command completions
// - Busy flag while operations run
module sfcf_top import sfcf_pkg::*; (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] data_line_in,
	output logic [3:0] data_line_out,
	output logic [3:0] data_line_oe,
	output logic [23:0] rd_addr,
	output logic rd_secure,
	input wire logic [7:0] rd_data,
	output logic [7:0] prog_data,
	output logic prog_valid,
	input wire logic prog_ready,
	output logic op_start,
	output logic [4:0] op_kind,
	output logic [23:0] op_addr,
	output logic op_volatile,
	output logic op_reject,
	input wire logic op_done,
	input wire logic prot_en,
	input wire logic [23:0] prot_lo,
	input wire logic [23:0] prot_hi,
	output logic [15:0] status_bits,
	output logic [7:0] config_reg,
	output logic intr_enable,
	output logic hold_active
);
	// ==========================================
	// Pin synchronisers
	logic [3:0] d_m;
	logic [3:0] d_s;
	logic cs_m, cs_s, cs_d, ck_m, ck_s, ck_d;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			d_m <= 4'hF;
			d_s <= 4'hF;
			cs_m <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			ck_m <= 1'b0;
			ck_s <= 1'b0;
			ck_d <= 1'b0;
		end else begin
			d_m <= data_line_in;
			d_s <= d_m;
			cs_m <= cs_n;
			cs_s <= cs_m;
			cs_d <= cs_s;
			ck_m <= sclk;
			ck_s <= ck_m;
			ck_d <= ck_s;
		end
	end

	// ==========================================
	// Command decode
	function automatic sfcf_cmd_t sfcf_mk(input sfcf_kind_t k, input logic [6:0] fl,
			input logic [2:0] alw, input logic [2:0] dlw, input logic [23:0] rm);
		sfcf_cmd_t c;
		c.ok = 1'b1;
		c.kind = k;
		c.fl = fl;
		c.alw = alw;
		c.dlw = dlw;
		c.rmask = rm;
		return c;
	endfunction

	function automatic sfcf_cmd_t sfcf_decode(input logic [7:0] op, input logic qe);
		sfcf_cmd_t c;
		c = '0;
		case (op)
			`SFCF_OP_READ: c = sfcf_mk(K_READ, 7'b1001100, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_FAST: c = sfcf_mk(K_READ, 7'b1101100, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_DOR: c = sfcf_mk(K_READ, 7'b1101100, 3'd1, 3'd2, 24'h0);
			`SFCF_OP_DIOR: c = sfcf_mk(K_READ, 7'b1101100, 3'd2, 3'd2, 24'h0);
			`SFCF_OP_QOR: c = sfcf_mk(K_READ, 7'b1101101, 3'd1, 3'd4, 24'h0);
			`SFCF_OP_QIOR: c = sfcf_mk(K_READ, 7'b1101101, 3'd4, 3'd4, 24'h0);
			`SFCF_OP_PGE: c = sfcf_mk(K_ERASE, 7'b1000110, 3'd1, 3'd1, `SFCF_PAGE_MASK);
			`SFCF_OP_SECE: c = sfcf_mk(K_ERASE, 7'b1000110, 3'd1, 3'd1, `SFCF_SECT_MASK);
			`SFCF_OP_HBE: c = sfcf_mk(K_ERASE, 7'b1000110, 3'd1, 3'd1, `SFCF_HBLK_MASK);
			`SFCF_OP_FBE: c = sfcf_mk(K_ERASE, 7'b1000110, 3'd1, 3'd1, `SFCF_FBLK_MASK);
			`SFCF_OP_CE1, `SFCF_OP_CE2: c = sfcf_mk(K_CHIPERASE, 7'b0000110, 3'd1, 3'd1,
				`SFCF_CHIP_MASK);
			`SFCF_OP_PP: c = sfcf_mk(K_PROG, 7'b1010110, 3'd1, 3'd1, `SFCF_PAGE_MASK);
			`SFCF_OP_DPP: c = sfcf_mk(K_PROG, 7'b1010110, 3'd1, 3'd2, `SFCF_PAGE_MASK);
			`SFCF_OP_QPP: c = sfcf_mk(K_PROG, 7'b1010111, 3'd1, 3'd4, `SFCF_PAGE_MASK);
			`SFCF_OP_SUS1, `SFCF_OP_SUS2, `SFCF_OP_RES1, `SFCF_OP_RES2:
				c = sfcf_mk(K_SUSRES, 7'b0000000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_WEN: c = sfcf_mk(K_SET_WRITE_LATCH_CMD, 7'b0000000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_WDI: c = sfcf_mk(K_CLEAR_WRITE_LATCH_CMD, 7'b0000000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_VWEN: c = sfcf_mk(K_VOLATILE_STATUS_WRITE_ENABLE_CMD, 7'b0000000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_SAE: c = sfcf_mk(K_SECERASE, 7'b1000100, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_SAP: c = sfcf_mk(K_SECPROG, 7'b1010100, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_SAR: c = sfcf_mk(K_SECREAD, 7'b1101100, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_RSL: c = sfcf_mk(K_STLO, 7'b0001000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_RSH: c = sfcf_mk(K_STHI, 7'b0001000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_RCF: c = sfcf_mk(K_CFGRD, 7'b0001000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_INTE: c = sfcf_mk(K_INTE, 7'b0010000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_WSR: c = sfcf_mk(K_STATUS_WRITE_CMD, 7'b0010000, 3'd1, 3'd1, 24'h0);
			`SFCF_OP_WCR: c = sfcf_mk(K_CONFIG_WRITE_CMD, 7'b0010000, 3'd1, 3'd1, 24'h0);
			default: c = '0;
		endcase
		if (c.fl[0] && !qe) begin
			c.ok = 1'b0;
		end
		return c;
	endfunction

	// ==========================================
	// Shared terms
	sfcf_state_t state;
	sfcf_cmd_t cmd;
	sfcf_cmd_t dec;
	logic [7:0] sh, sh_next, tx, tx_val, src_byte, wsr0, wsr1;
	logic [2:0] bitpos, w_in;
	logic [3:0] pos_sum, txleft, lane_val, lane_oe;
	logic [1:0] bcnt, dcnt;
	logic [23:0] addr, r_lo, r_hi;
	logic [13:0] sr;
	logic write_enable_latch, busy_flag, vol_arm, lost, tx_on;
	logic hold_n, cs_rise, ck_rise, ck_fall, rx_en, rx_done, quad_mode;
	logic prot_hit, wr_ok, tx_fall, bnd, go, eng, is_prog, push, pop, bv1;
	logic [7:0] be1;

	assign hold_n = d_s[3];
	assign cs_rise = cs_s & ~cs_d;
	assign ck_rise = ck_s & ~ck_d & ~cs_s & ~hold_active;
	assign ck_fall = ~ck_s & ck_d & ~cs_s & ~hold_active;
	assign quad_mode = cmd.fl[0] & (state != ST_CMD);
	assign rx_en = ck_rise & (state != ST_STANDBY) & ~((state == ST_DATA) & cmd.fl[3]);
	assign pos_sum = {1'b0, bitpos} + {1'b0, w_in};
	assign rx_done = rx_en & pos_sum[3];
	assign dec = sfcf_decode(sh_next, sr[`SFCF_SR_QE - 2]);
	assign r_lo = addr & ~cmd.rmask;
	assign r_hi = addr | cmd.rmask;
	assign prot_hit = prot_en & cmd.fl[1] & (r_lo <= prot_hi) & (r_hi >= prot_lo);
	assign wr_ok = write_enable_latch & ~busy_flag & ~prot_hit;
	assign tx_fall = ck_fall & (state == ST_DATA) & cmd.fl[3];
	assign tx_val = (txleft == 4'h0) ? src_byte : tx;
	assign bnd = (state == ST_DATA) & (bitpos == 3'd0) & ~cmd.fl[3];
	assign is_prog = (cmd.kind == K_PROG) | (cmd.kind == K_SECPROG);

	always_comb begin
		case (state)
			ST_CMD: w_in = 3'd1;
			ST_ADDR, ST_DUMMY: w_in = cmd.alw;
			default: w_in = cmd.dlw;
		endcase
		case (w_in)
			3'd2: sh_next = {sh[5:0], d_s[1:0]};
			3'd4: sh_next = {sh[3:0], d_s};
			default: sh_next = {sh[6:0], d_s[0]};
		endcase
		case (cmd.kind)
			K_STLO: src_byte = {sr[5:0], write_enable_latch, busy_flag};
			K_STHI: src_byte = sr[13:6];
			K_CFGRD: src_byte = config_reg;
			default: src_byte = rd_data;
		endcase
		case (cmd.dlw)
			3'd2: lane_val = {2'b00, tx_val[7:6]};
			3'd4: lane_val = tx_val[7:4];
			default: lane_val = {2'b00, tx_val[7], 1'b0};
		endcase
		case (cmd.dlw)
			3'd2: lane_oe = 4'h3;
			3'd4: lane_oe = 4'hF;
			default: lane_oe = 4'h2;
		endcase
	end

	// Decides at CS rise whether a write-type command may run
	always_comb begin
		go = 1'b0;
		eng = 1'b0;
		if (bnd) begin
			case (cmd.kind)
				K_SET_WRITE_LATCH_CMD, K_CLEAR_WRITE_LATCH_CMD, K_VOLATILE_STATUS_WRITE_ENABLE_CMD: go = (dcnt == 2'd0);
				K_SUSRES: begin
					go = (dcnt == 2'd0);
					eng = 1'b1;
				end
				K_ERASE, K_CHIPERASE, K_SECERASE: begin
					go = (dcnt == 2'd0) & wr_ok;
					eng = 1'b1;
				end
				K_PROG, K_SECPROG: begin
					go = (dcnt != 2'd0) & wr_ok & ~lost;
					eng = 1'b1;
				end
				K_STATUS_WRITE_CMD: begin
					go = (dcnt != 2'd0) & (write_enable_latch | vol_arm) & ~busy_flag;
					eng = ~vol_arm;
				end
				K_CONFIG_WRITE_CMD: go = (dcnt == 2'd1) & write_enable_latch & ~busy_flag;
				K_INTE: go = (dcnt == 2'd1);
				default: go = 1'b0;
			endcase
		end
	end

	// ==========================================
	// Receive sequencer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_CMD;
			cmd <= '0;
			sh <= 8'h00;
			bitpos <= 3'd0;
			bcnt <= 2'd0;
			dcnt <= 2'd0;
			addr <= 24'h000000;
			wsr0 <= 8'h00;
			wsr1 <= 8'h00;
		end else if (cs_s) begin
			// CS high clears state, bit and byte counts and address, also mid-hold
			state <= ST_CMD;
			bitpos <= 3'd0;
			bcnt <= 2'd0;
			dcnt <= 2'd0;
			addr <= 24'h000000;
		end else if (rx_en) begin
			sh <= sh_next;
			bitpos <= pos_sum[2:0];
			if (pos_sum[3]) begin
				case (state)
					ST_CMD: begin
						cmd <= dec;
						if (!dec.ok || (busy_flag && dec.fl[2])) begin
							state <= ST_STANDBY;
						end else if (dec.fl[6]) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_DATA;
						end
					end
					ST_ADDR: begin
						addr <= {addr[15:0], sh_next};
						bcnt <= bcnt + 2'd1;
						if (bcnt == 2'd2) begin
							state <= cmd.fl[5] ? ST_DUMMY : ST_DATA;
						end
					end
					ST_DUMMY: state <= ST_DATA;
					ST_DATA: begin
						if (dcnt != 2'd3) begin
							dcnt <= dcnt + 2'd1;
						end
						if (dcnt == 2'd0) begin
							wsr0 <= sh_next;
						end
						if (dcnt == 2'd1) begin
							wsr1 <= sh_next;
						end
					end
					default: state <= state;
				endcase
			end
		end
	end

	// ==========================================
	// Transmit path
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx <= 8'h00;
			txleft <= 4'h0;
			tx_on <= 1'b0;
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
			rd_addr <= 24'h000000;
			rd_secure <= 1'b0;
		end else if (cs_s) begin
			txleft <= 4'h0;
			tx_on <= 1'b0;
			data_line_oe <= 4'h0;
		end else begin
			if (rx_done && state == ST_ADDR && bcnt == 2'd2) begin
				rd_addr <= {addr[15:0], sh_next};
				rd_secure <= (cmd.kind == K_SECREAD);
			end
			if (tx_fall) begin
				tx_on <= 1'b1;
				data_line_out <= lane_val;
				tx <= tx_val << cmd.dlw;
				txleft <= ((txleft == 4'h0) ? 4'h8 : txleft) - {1'b0, cmd.dlw};
				if (txleft == 4'h0 && (cmd.kind == K_READ || cmd.kind == K_SECREAD)) begin
					rd_addr <= rd_addr + 24'h000001;
				end
			end
			// Hold pin low floats the outputs even before hold itself starts
			if ((tx_on || tx_fall) && (hold_n || quad_mode)) begin
				data_line_oe <= lane_oe;
			end else begin
				data_line_oe <= 4'h0;
			end
		end
	end

	// ==========================================
	// Hold tracking
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_active <= 1'b0;
		end else if (cs_s || quad_mode) begin
			hold_active <= 1'b0;
		end else if (!ck_s) begin
			hold_active <= ~hold_n;
		end
	end

	// ==========================================
	// Status, latch and operation launch
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			write_enable_latch <= 1'b0;
			busy_flag <= 1'b0;
			vol_arm <= 1'b0;
			sr <= `SFCF_SR_RST;
			config_reg <= `SFCF_CR_RST;
			intr_enable <= 1'b0;
			op_start <= 1'b0;
			op_kind <= 5'h00;
			op_addr <= 24'h000000;
			op_volatile <= 1'b0;
			op_reject <= 1'b0;
			status_bits <= 16'h0000;
		end else begin
			op_start <= 1'b0;
			op_reject <= 1'b0;
			status_bits <= {sr, write_enable_latch, busy_flag};
			// Busy is never touched by hold
			if (op_done) begin
				busy_flag <= 1'b0;
			end
			if (cs_rise && cmd.ok && !cmd.fl[3] && state != ST_CMD) begin
				vol_arm <= go & (cmd.kind == K_VOLATILE_STATUS_WRITE_ENABLE_CMD);
				op_reject <= ~go;
				op_kind <= cmd.kind;
				op_addr <= addr;
				op_volatile <= vol_arm;
				if (go) begin
					case (cmd.kind)
						K_SET_WRITE_LATCH_CMD: write_enable_latch <= 1'b1;
						K_CLEAR_WRITE_LATCH_CMD: write_enable_latch <= 1'b0;
						K_STATUS_WRITE_CMD: begin
							sr[5:0] <= wsr0[7:2];
							if (dcnt == 2'd2) begin
								sr[13:6] <= wsr1;
							end
							write_enable_latch <= 1'b0;
						end
						K_CONFIG_WRITE_CMD: begin
							config_reg <= wsr0;
							write_enable_latch <= 1'b0;
						end
						K_INTE: intr_enable <= 1'b1;
						K_SUSRES: write_enable_latch <= write_enable_latch;
						default: write_enable_latch <= 1'b0;
					endcase
					op_start <= eng;
					// Set wins over a completion in the same cycle
					if (eng && cmd.kind != K_SUSRES) begin
						busy_flag <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================
	// Two-entry program data buffer
	// Head entry drives the outputs; a full buffer marks the command lost
	assign pop = prog_valid & prog_ready;
	assign push = rx_done & (state == ST_DATA) & is_prog & wr_ok & ~bv1;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prog_valid <= 1'b0;
			prog_data <= 8'h00;
			bv1 <= 1'b0;
			be1 <= 8'h00;
			lost <= 1'b0;
		end else begin
			if (cs_s) begin
				lost <= 1'b0;
			end else if (rx_done && state == ST_DATA && is_prog && bv1) begin
				lost <= 1'b1;
			end
			if (pop) begin
				if (bv1) begin
					prog_data <= be1;
					bv1 <= push;
					be1 <= sh_next;
				end else if (push) begin
					prog_data <= sh_next;
				end else begin
					prog_valid <= 1'b0;
				end
			end else if (push) begin
				if (!prog_valid) begin
					prog_data <= sh_next;
					prog_valid <= 1'b1;
				end else begin
					be1 <= sh_next;
					bv1 <= 1'b1;
				end
			end
		end
	end
endmodule // sfcf_top

// ==== verif/sfcf_top_props.sv ====
`timescale 1ns/10ps
// ==========================================
// Port-level properties
module sfcf_top_props import sfcf_pkg::*; (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic [3:0] data_line_oe,
	input wire logic op_start,
	input wire logic [4:0] op_kind,
	input wire logic op_reject,
	input wire logic op_done,
	input wire logic [15:0] status_bits,
	input wire logic hold_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Suspend and resume neither need nor consume the latch
	wire logic modify = op_start && op_kind != K_SUSRES;
	sequence busy_up;
		##[1:3] status_bits[0];
	endsequence
	sequence latch_down;
		##[1:3] !status_bits[1];
	endsequence
	a_start_reject_excl: assert property (!(op_start && op_reject))
		else $error("start and reject together");
	a_start_when_idle: assert property (op_start |-> !status_bits[0])
		else $error("start while busy");
	a_busy_follows: assert property (modify |-> busy_up)
		else $error("busy not raised");
	a_latch_clears: assert property (modify |-> latch_down)
		else $error("latch not cleared");
	a_latch_needed: assert property (modify |-> $past(status_bits[1], 3))
		else $error("start without latch");
	a_done_idles: assert property (op_done && !op_start |-> ##[1:3] !status_bits[0])
		else $error("busy stuck after done");
	a_oe_shape: assert property (data_line_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("bad line enable");
	a_cs_drops_oe: assert property ($rose(cs_n) |-> ##[1:6] data_line_oe == 4'h0)
		else $error("output kept after select");
	a_hold_quiet: assert property (hold_active && $past(hold_active) |-> data_line_oe == 4'h0)
		else $error("output during hold");
	a_end_at_select: assert property (op_start || op_reject |-> cs_n && $past(cs_n, 2))
		else $error("command ended while selected");
endmodule // sfcf_top_props

bind sfcf_top sfcf_top_props u_props (.sys_clk, .resetn, .cs_n, .data_line_oe, .op_start,
	.op_kind, .op_reject, .op_done, .status_bits, .hold_active);

// ==== verif/sfcf_spi_host.sv ====
`timescale 1ns/10ps
// ==========================================
// SPI host: changes lines on clock fall, 200 ns bit time
module sfcf_spi_host (
	output logic cs_n,
	output logic sclk,
	output logic [3:0] host_out,
	output logic [3:0] host_oe,
	input wire logic [3:0] line
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		host_out = 4'hC;
		host_oe = 4'hD;
	end
	// Clock parks first so its edge is never seen inside the frame
	task automatic start(input logic m3);
		sclk = m3;
		#100 cs_n = 1'b0;
		#100;
	endtask
	task automatic tx(input logic [7:0] b, input int w, input int n);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		for (int i = 8 - w; i >= 8 - n; i -= w) begin
			sclk = 1'b0;
			host_out = 4'hC & ~m | 4'(b >> i) & m;
			host_oe = 4'hC | m;
			#100 sclk = 1'b1;
			#100;
		end
	endtask
	// Sampled late in the high phase: the device launches well after the fall
	task automatic rx(output logic [7:0] b, input int w);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		b = 8'h00;
		host_oe = w == 4 ? 4'h0 : 4'hC;
		for (int i = 0; i < 8; i += w) begin
			sclk = 1'b0;
			#100 sclk = 1'b1;
			#100 b = 8'(b << w) | 8'((w == 1 ? line >> 1 : line) & m);
		end
	endtask
	task automatic hold(input logic v);
		sclk = 1'b0;
		#100 host_out[3] = v;
		#200;
	endtask
	task automatic stop(input logic m3);
		sclk = m3;
		#100 cs_n = 1'b1;
		host_oe = 4'hD;
		host_out = 4'hC;
		#200;
	endtask
endmodule // sfcf_spi_host

// ==== verif/sfcf_top_tb.sv ====
`timescale 1ns/10ps
// ==========================================
// Bench top
module sfcf_top_tb import sfcf_pkg::*; ;
	logic sys_clk = 1'b0, resetn = 1'b0, tgl = 1'b0, oe_seen = 1'b0;
	logic cs_n, sclk, rd_secure, prog_valid, op_start, op_volatile, op_reject;
	logic intr_enable, hold_active;
	logic prog_ready = 1'b0, op_done = 1'b0, prot_en = 1'b0, stall = 1'b0;
	logic [3:0] host_out, host_oe, data_line_in, data_line_out, data_line_oe;
	logic [23:0] rd_addr, op_addr, prot_lo = 24'h00FFF0, prot_hi = 24'h00FFF0;
	logic [7:0] rd_data = 8'h00, prog_data, config_reg;
	logic [4:0] op_kind, lkind;
	logic [15:0] status_bits;
	logic [31:0] seed = 32'h00003E9F;
	logic [7:0] pq[$];
	int err_count = 0, samples_checked = 0, n_start = 0, n_rej = 0;
	logic [7:0] mop[4] = '{8'h3B, 8'hBB, 8'h6B, 8'hEB};
	int mwa[4] = '{1, 2, 1, 4};
	int mwd[4] = '{2, 2, 4, 4};
	logic [7:0] eop[11] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2, 8'h32,
		8'h44, 8'h42};
	sfcf_kind_t ekd[11] = '{K_ERASE, K_ERASE, K_ERASE, K_ERASE, K_CHIPERASE, K_CHIPERASE,
		K_PROG, K_PROG, K_PROG, K_SECERASE, K_SECPROG};
	int edn[11] = '{0, 0, 0, 0, 0, 0, 2, 2, 2, 0, 2};
	int ewd[11] = '{1, 1, 1, 1, 1, 1, 1, 2, 4, 1, 1};

	sfcf_top DUT (.sys_clk, .resetn, .cs_n, .sclk, .data_line_in, .data_line_out, .data_line_oe,
		.rd_addr, .rd_secure, .rd_data, .prog_data, .prog_valid, .prog_ready, .op_start, .op_kind,
		.op_addr, .op_volatile, .op_reject, .op_done, .prot_en, .prot_lo, .prot_hi, .status_bits,
		.config_reg, .intr_enable, .hold_active);
	sfcf_spi_host h (.cs_n, .sclk, .host_out, .host_oe, .line(data_line_in));

	always #12.5 sys_clk = ~sys_clk;
	// Lines nobody drives wander every cycle rather than keep an old value
	assign data_line_in = data_line_oe & data_line_out
		| ~data_line_oe & (host_oe & host_out | ~host_oe & {4{tgl}});

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction

	always @(negedge sys_clk) begin
		rd_data <= mem(rd_addr);
		prog_ready <= !stall && rnd() % 3 != 0;
	end
	always @(posedge sys_clk) begin
		tgl <= ~tgl;
		if (op_start) begin
			n_start++;
			lkind = op_kind;
		end
		if (op_reject) n_rej++;
		if (prog_valid && prog_ready) pq.push_back(prog_data);
		if (|data_line_oe) oe_seen = 1'b1;
	end

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] act);
		samples_checked++;
		if (exp !== act) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, act);
		end
	endtask
	// Expects {started, rejected}; x extra loose bits end the frame off a byte
	task automatic wop(input logic [7:0] op, input int nb, input logic [47:0] d, input int x,
		input logic [1:0] exp);
		int s, r;
		s = n_start;
		r = n_rej;
		h.start(1'b0);
		h.tx(op, 1, 8);
		for (int i = nb - 1; i >= 0; i--) h.tx(d[8 * i +: 8], 1, 8);
		if (x > 0) h.tx(8'h00, 1, x);
		h.stop(1'b0);
		chk("start_reject", exp, 24'({n_start != s, n_rej != r}));
	endtask
	task automatic rd(input logic [7:0] op, input int wa, input int dm, input int wd,
		input logic m3, input logic ok);
		logic [23:0] a;
		logic [7:0] b;
		a = 24'(rnd()) & 24'h1FFFFF;
		oe_seen = 1'b0;
		h.start(m3);
		h.tx(op, 1, 8);
		for (int i = 2; i >= 0; i--) h.tx(a[8 * i +: 8], wa, 8);
		if (dm > 0) h.tx(8'h00, wa, 8);
		for (int i = 0; i < 3; i++) begin
			h.rx(b, wd);
			if (ok) chk("read_data", mem(a + 24'(i)), b);
		end
		h.stop(m3);
		if (!ok) chk("standby_oe", 0, oe_seen);
	endtask
	task automatic st(input logic [7:0] op, input logic [7:0] exp, input logic hd);
		logic [7:0] b;
		h.start(1'b0);
		h.tx(op, 1, 8);
		if (hd) begin
			h.hold(1'b0);
			chk("hold_state", 24'h10, {hold_active, data_line_oe});
			h.hold(1'b1);
		end
		h.rx(b, 1);
		h.stop(1'b0);
		chk("status_byte", exp, b);
	endtask
	task automatic done();
		@(negedge sys_clk) op_done = 1'b1;
		@(negedge sys_clk) op_done = 1'b0;
		#100;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		logic [23:0] a;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) resetn = 1'b1;
		#200;
		rd(8'h03, 1, 0, 1, 1'b0, 1'b1);
		rd(8'h0B, 1, 1, 1, 1'b1, 1'b1);
		rd(8'hE0, 1, 0, 1, 1'b0, 1'b0);
		rd(8'h6B, 1, 1, 4, 1'b0, 1'b0);
		wop(8'h01, 2, 48'h0002, 0, 2'b01);
		wop(8'h06, 0, 0, 0, 2'b00);
		chk("latch_set", 1, status_bits[1]);
		wop(8'h04, 0, 0, 0, 2'b00);
		chk("latch_clear", 0, status_bits[1]);
		wop(8'h06, 0, 0, 0, 2'b00);
		wop(8'h20, 3, 48'h001000, 3, 2'b01);
		wop(8'h06, 0, 0, 0, 2'b00);
		// Window drawn at random inside the targeted 32 KB block
		prot_lo = 24'h008000 | (24'(rnd()) & 24'h007FFF);
		prot_hi = prot_lo + 24'(rnd() % 16);
		prot_en = 1'b1;
		wop(8'h52, 3, 48'h008123, 0, 2'b01);
		prot_en = 1'b0;
		wop(8'h06, 0, 0, 0, 2'b00);
		wop(8'h01, 2, 48'h0002, 0, 2'b10);
		done();
		chk("quad_bit", 1, status_bits[9]);
		foreach (mop[i]) rd(mop[i], mwa[i], 1, mwd[i], 1'(i), 1'b1);
		foreach (eop[i]) begin
			a = 24'(rnd()) & 24'h1FFF00;
			wop(8'h06, 0, 0, 0, 2'b00);
			pq.delete();
			lkind = 5'h00;
			h.start(1'b0);
			h.tx(eop[i], 1, 8);
			if (ekd[i] != K_CHIPERASE) for (int k = 2; k >= 0; k--) h.tx(a[8 * k +: 8], 1, 8);
			for (int k = 0; k < edn[i]; k++) h.tx(8'hC0 + 8'(k), ewd[i], 8);
			h.stop(1'b0);
			chk("kind", ekd[i], lkind);
			chk("latch_busy", 2'b01, status_bits[1:0]);
			if (ekd[i] != K_CHIPERASE) chk("op_addr", a, op_addr);
			rd(8'h03, 1, 0, 1, 1'b0, 1'b0);
			st(8'h05, 8'h01, 1'b0);
			done();
			chk("idle", 0, status_bits[0]);
			for (int k = 0; k < edn[i]; k++) chk("prog_data", 8'hC0 + 8'(k), pq[k]);
		end
		// Third byte with the buffer full and the engine stalled is refused
		stall = 1'b1;
		pq.delete();
		wop(8'h06, 0, 0, 0, 2'b00);
		wop(8'h02, 6, 48'h000100A1A2A3, 0, 2'b01);
		stall = 1'b0;
		#400;
		// The two staged bytes still drain; the engine discards them on reject
		chk("drained", 2, pq.size());
		chk("drained_head", 8'hA1, pq[0]);
		wop(8'h50, 0, 0, 0, 2'b00);
		wop(8'h01, 2, 48'h0402, 0, 2'b00);
		chk("volatile_sr", 24'h0204, status_bits);
		chk("volatile_flag", 1, op_volatile);
		st(8'h35, 8'h02, 1'b1);
		wop(8'h25, 1, 0, 0, 2'b00);
		chk("intr_en", 1, intr_enable);
		report_and_stop();
	end
	// About five times the expected run, still under 100k cycles
	initial begin
		#2_000_000;
		err_count++;
		report_and_stop();
	end
endmodule // sfcf_top_tb
